// ==== verilog/ckdoc_pkg.sv ====
// Package for the clock divider and oscillator control block.
// Assumes a single 125 MHz system clock and an AXI4-Lite register bus.
package ckdoc_pkg;
	// Register byte offsets
	localparam logic [3:0] CKDOC_OFS_PRESCALE = 4'h0;
	localparam logic [3:0] CKDOC_OFS_CPUCTL = 4'h4;
	localparam logic [3:0] CKDOC_OFS_SLOWOSC = 4'h8;
	localparam logic [3:0] CKDOC_OFS_STAB = 4'hC;
	// Reset values
	localparam logic [1:0] CKDOC_RST_PRESCALE = 2'h0;
	localparam logic CKDOC_RST_CPUDIV = 1'b0;
	localparam logic CKDOC_RST_SLOWSTOP = 1'b0;
	localparam logic [1:0] CKDOC_RST_STAB = 2'h0;
	// Field positions
	localparam int CKDOC_POS_CPUDIV = 1;
	localparam int CKDOC_POS_SLOWSTOP = 0;
	// Stabilization wait exponents of 2, in system clock periods
	localparam int CKDOC_STAB_EXP0 = 10;
	localparam int CKDOC_STAB_EXP1 = 12;
	localparam int CKDOC_STAB_EXP2 = 15;
	localparam int CKDOC_STAB_EXP3 = 17;
	localparam int CKDOC_STAB_W = 18;
	// Divider counter width, reaches divide by 16
	localparam int CKDOC_DIV_W = 4;
	localparam logic [1:0] CKDOC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CKDOC_RESP_SLVERR = 2'h2;
	// System clock source chosen by the option setting
	typedef enum logic [1:0] {
		CKDOC_SRC_HS_INT = 2'h0,
		CKDOC_SRC_RESONATOR = 2'h1,
		CKDOC_SRC_EXT = 2'h2
	} ckdoc_src_type;
	typedef enum logic [1:0] {
		CKDOC_ST_RUN = 2'h0,
		CKDOC_ST_STOP = 2'h1,
		CKDOC_ST_WAIT = 2'h3
	} ckdoc_state_type;
endpackage

// ==== verilog/ckdoc_ratio_if.sv ====
// Carries the selected ratio and the decoded divisors from decode to divider.
// Assumes the same clock on both sides.
`timescale 1ns/10ps
interface ckdoc_ratio_if;
	logic [2:0] sel;
	logic [3:0] cpu_div;
	logic [3:0] per_div;
	logic legal;
	modport decoder(input sel, output cpu_div, output per_div, output legal);
	modport user(output sel, input cpu_div, input per_div, input legal);
endinterface

// ==== verilog/ckdoc_ratio_dec.sv ====
// Ratio decoder: maps the three select bits to cpu and peripheral divisors.
// Assumes only the codes 000 to 101 are legal.
`timescale 1ns/10ps
module ckdoc_ratio_dec
	import ckdoc_pkg::*;
(
	ckdoc_ratio_if.decoder rif // Ratio select and divisors
);
	// Ratio table
	// Divide by 16 does not fit four bits and is coded as 0
	assign rif.cpu_div = (rif.sel == 3'h0) ? 4'h1 :
		(rif.sel == 3'h1) ? 4'h4 :
		(rif.sel == 3'h2) ? 4'h2 :
		(rif.sel == 3'h3) ? 4'h8 :
		(rif.sel == 3'h4) ? 4'h4 : 4'h0;
	assign rif.per_div = (rif.sel == 3'h0) ? 4'h1 :
		(rif.sel == 3'h1) ? 4'h1 :
		(rif.sel == 3'h2) ? 4'h2 :
		(rif.sel == 3'h3) ? 4'h2 : 4'h4;
	assign rif.legal = (rif.sel <= 3'h5);
endmodule // ckdoc_ratio_dec

// ==== verilog/ckdoc_div.sv ====
// Clock-enable divider: one pulse every div cycles of the system clock.
// Assumes div is a power of two up to 16, with 0 standing for 16.
`timescale 1ns/10ps
module ckdoc_div
	import ckdoc_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic reset, // Async reset, active high
	input wire logic ce, // Clock enable
	input wire logic [3:0] div, // Divisor, 1 to 16 (0 means 16)
	output logic pulse // One-cycle enable at each divided edge
);
	logic [CKDOC_DIV_W-1:0] cnt_reg;
	// Every instance counts in lockstep from reset, so the edges of all ratios line up
	// and a ratio change cuts a period short, by one cycle, only when it leaves a divisor of 1
	wire logic [CKDOC_DIV_W-1:0] mask = div - 4'h1;
	wire logic wrap = ((cnt_reg & mask) == mask);
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_reg <= '0;
			pulse <= 1'b0;
		end else if (ce) begin
			cnt_reg <= cnt_reg + 4'h1;
			pulse <= wrap;
		end
	end
endmodule // ckdoc_div

// ==== verilog/ckdoc_top.sv ====
// Clock divider and oscillator control block with an AXI4-Lite register slave.
// Assumes option settings are static inputs; divided clocks leave as enables.
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module ckdoc_top
	import ckdoc_pkg::*;
(
	input wire logic clk_sys, // 125 MHz system clock
	input wire logic reset, // Async reset, active high
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic [1:0] sys_src, // Option setting: system clock source
	input wire logic slow_osc_soft_stop_allow, // Option setting: slow osc may stop
	input wire logic slow_osc_clk, // Slow oscillator raw clock
	input wire logic wdt_stop_req, // Watchdog asks to stop
	input wire logic wdt_sysclk_req, // Watchdog asks for system clock
	input wire logic stop_mode, // STOP mode active
	input wire logic stop_release, // Pulse: STOP mode release
	output logic cpu_clk_en, // CPU clock enable pulse
	output logic per_clk_en, // Peripheral clock enable pulse
	output logic slow_osc_run, // Slow oscillator enable
	output logic wdt_clk, // Watchdog clock
	output logic wdt_stopped, // Watchdog stop honoured
	output logic tmh_clk, // Interval timer clock
	output logic stab_busy, // Stabilization wait under way
	input wire logic [31:0] s_axi_awaddr, // AXI write address
	input wire logic s_axi_awvalid, // AXI write address valid
	output logic s_axi_awready, // AXI write address ready
	input wire logic [31:0] s_axi_wdata, // AXI write data
	input wire logic [3:0] s_axi_wstrb, // AXI write strobes
	input wire logic s_axi_wvalid, // AXI write data valid
	output logic s_axi_wready, // AXI write data ready
	output logic [1:0] s_axi_bresp, // AXI write response
	output logic s_axi_bvalid, // AXI write response valid
	input wire logic s_axi_bready, // AXI write response ready
	input wire logic [31:0] s_axi_araddr, // AXI read address
	input wire logic s_axi_arvalid, // AXI read address valid
	output logic s_axi_arready, // AXI read address ready
	output logic [31:0] s_axi_rdata, // AXI read data
	output logic [1:0] s_axi_rresp, // AXI read response
	output logic s_axi_rvalid, // AXI read valid
	input wire logic s_axi_rready // AXI read ready
);
	logic [1:0] prescale_reg;
	logic cpu_div_sel_reg;
	logic slow_stop_reg;
	logic [1:0] stab_reg;
	logic [2:0] ratio_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [3:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wstrb0_reg;
	ckdoc_state_type state_reg;
	ckdoc_state_type state_next;
	logic [CKDOC_STAB_W-1:0] stab_cnt_reg;
	logic [CKDOC_STAB_W-1:0] stab_cnt_next;

	ckdoc_ratio_if rif();
	// Applied select bits from ratio_reg, high middle low
	assign rif.sel = ratio_reg;
	ckdoc_ratio_dec u_dec (
		.rif(rif.decoder)
	);

	wire logic cpu_pulse;
	wire logic per_pulse;
	wire logic bound_pulse;
	ckdoc_div u_cpu_div (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.div(rif.cpu_div),
		.pulse(cpu_pulse)
	);
	ckdoc_div u_per_div (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.div(rif.per_div),
		.pulse(per_pulse)
	);
	// Boundary tick of the slowest ratio, divide by 16, times the ratio swap for both dividers
	ckdoc_div u_bound (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.div(4'h0),
		.pulse(bound_pulse)
	);

	wire logic [2:0] req_sel = {prescale_reg, cpu_div_sel_reg};
	// Prohibited codes are never loaded; the last legal ratio is kept
	wire logic req_legal = (req_sel <= 3'h5);

	// Ratio swap only at the slowest clock boundary
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ratio_reg <= 3'h0;
		end else if (ce && bound_pulse && req_legal) begin
			ratio_reg <= req_sel;
		end
	end

	// Outputs are registered enables, gated during STOP
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cpu_clk_en <= 1'b0;
			per_clk_en <= 1'b0;
		end else if (ce) begin
			cpu_clk_en <= cpu_pulse && (state_reg == CKDOC_ST_RUN);
			per_clk_en <= per_pulse && (state_reg == CKDOC_ST_RUN);
		end
	end

	// Stop honoured only when the option allows it
	wire logic slow_run_next = !(slow_stop_reg && slow_osc_soft_stop_allow);
	// Watchdog stop or sysclk needs the soft-stop option
	wire logic wdt_sys_ok = wdt_sysclk_req && slow_osc_soft_stop_allow;
	wire logic wdt_stop_ok = wdt_stop_req && slow_osc_soft_stop_allow;
	// Slow oscillator feeds watchdog and interval timer
	wire logic slow_gated = slow_osc_clk && slow_osc_run;
	wire logic wdt_clk_next = wdt_stop_ok ? 1'b0 : (wdt_sys_ok ? cpu_pulse : slow_gated);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			slow_osc_run <= 1'b1;
			wdt_clk <= 1'b0;
			tmh_clk <= 1'b0;
			wdt_stopped <= 1'b0;
		end else if (ce) begin
			slow_osc_run <= slow_run_next;
			wdt_clk <= wdt_clk_next;
			tmh_clk <= slow_gated;
			wdt_stopped <= wdt_stop_ok;
		end
	end

	// Wait length from the two-bit select
	wire logic [CKDOC_STAB_W-1:0] stab_len =
		(stab_reg == 2'h0) ? CKDOC_STAB_W'(1 << CKDOC_STAB_EXP0) :
		(stab_reg == 2'h1) ? CKDOC_STAB_W'(1 << CKDOC_STAB_EXP1) :
		(stab_reg == 2'h2) ? CKDOC_STAB_W'(1 << CKDOC_STAB_EXP2) :
		CKDOC_STAB_W'(1 << CKDOC_STAB_EXP3);
	wire logic needs_wait = (sys_src == CKDOC_SRC_RESONATOR);

	always_comb begin
		state_next = state_reg;
		stab_cnt_next = stab_cnt_reg;
		unique case (state_reg)
			CKDOC_ST_RUN: begin
				if (stop_mode) begin
					state_next = CKDOC_ST_STOP;
				end
			end
			CKDOC_ST_STOP: begin
				if (stop_release && needs_wait) begin
					state_next = CKDOC_ST_WAIT;
					stab_cnt_next = stab_len - 18'h1;
				end else if (stop_release) begin
					state_next = CKDOC_ST_RUN;
				end
			end
			CKDOC_ST_WAIT: begin
				if (stab_cnt_reg == '0) begin
					state_next = CKDOC_ST_RUN;
				end else begin
					stab_cnt_next = stab_cnt_reg - 18'h1;
				end
			end
			default: begin
				state_next = CKDOC_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= CKDOC_ST_RUN;
			stab_cnt_reg <= '0;
			stab_busy <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			stab_cnt_reg <= stab_cnt_next;
			stab_busy <= (state_next == CKDOC_ST_WAIT);
		end
	end

	// AXI4-Lite write: address and data taken in either order
	wire logic aw_take = s_axi_awvalid && s_axi_awready;
	wire logic w_take = s_axi_wvalid && s_axi_wready;
	wire logic have_aw = aw_held_reg || aw_take;
	wire logic have_w = w_held_reg || w_take;
	wire logic wr_go = have_aw && have_w && !s_axi_bvalid;
	wire logic [3:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr[3:0];
	wire logic [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
	wire logic wr_lane0 = w_held_reg ? wstrb0_reg : s_axi_wstrb[0];
	wire logic wr_hit = (wr_addr == CKDOC_OFS_PRESCALE) || (wr_addr == CKDOC_OFS_CPUCTL) ||
		(wr_addr == CKDOC_OFS_SLOWOSC) || (wr_addr == CKDOC_OFS_STAB);
	wire logic wr_upper_ok = (s_axi_awaddr[31:4] == '0) || aw_held_reg;
	wire logic wr_en = wr_go && wr_lane0;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0;
			wstrb0_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CKDOC_RESP_OKAY;
		end else if (ce) begin
			if (aw_take) begin
				awaddr_reg <= (s_axi_awaddr[31:4] == '0) ? s_axi_awaddr[3:0] : 4'h2;
			end
			if (w_take) begin
				wdata_reg <= s_axi_wdata;
				wstrb0_reg <= s_axi_wstrb[0];
			end
			aw_held_reg <= have_aw && !wr_go;
			w_held_reg <= have_w && !wr_go;
			s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !have_w && !s_axi_wready && !s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_hit && wr_upper_ok) ? CKDOC_RESP_OKAY : CKDOC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Unused bits are not stored and read as zero
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			prescale_reg <= CKDOC_RST_PRESCALE;
			cpu_div_sel_reg <= CKDOC_RST_CPUDIV;
			slow_stop_reg <= CKDOC_RST_SLOWSTOP;
			stab_reg <= CKDOC_RST_STAB;
		end else if (ce && wr_en && wr_upper_ok) begin
			if (wr_addr == CKDOC_OFS_PRESCALE) begin
				prescale_reg <= wr_data[1:0];
			end
			if (wr_addr == CKDOC_OFS_CPUCTL) begin
				cpu_div_sel_reg <= wr_data[CKDOC_POS_CPUDIV];
			end
			if (wr_addr == CKDOC_OFS_SLOWOSC) begin
				slow_stop_reg <= wr_data[CKDOC_POS_SLOWSTOP];
			end
			if (wr_addr == CKDOC_OFS_STAB) begin
				stab_reg <= wr_data[1:0];
			end
		end
	end

	// AXI4-Lite read
	wire logic [3:0] rd_addr = s_axi_araddr[3:0];
	wire logic rd_hit = (s_axi_araddr[31:4] == '0) &&
		((rd_addr == CKDOC_OFS_PRESCALE) || (rd_addr == CKDOC_OFS_CPUCTL) ||
		(rd_addr == CKDOC_OFS_SLOWOSC) || (rd_addr == CKDOC_OFS_STAB));
	wire logic [31:0] rd_data =
		(rd_addr == CKDOC_OFS_PRESCALE) ? {29'h0, ratio_reg == req_sel, prescale_reg} :
		(rd_addr == CKDOC_OFS_CPUCTL) ? {30'h0, cpu_div_sel_reg, 1'b0} :
		(rd_addr == CKDOC_OFS_SLOWOSC) ? {30'h0, slow_osc_run, slow_stop_reg} :
		{29'h0, stab_busy, stab_reg};
	wire logic ar_take = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= CKDOC_RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_hit ? rd_data : 32'h0;
				s_axi_rresp <= rd_hit ? CKDOC_RESP_OKAY : CKDOC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // ckdoc_top

// ==== verif/ckdoc_checker.sv ====
// Port checker for the clock control block.
// Assumes one clock domain and binding to ckdoc_top.
`timescale 1ns/10ps
module ckdoc_checker
	import ckdoc_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic reset, // Async reset
	input wire logic ce, // Clock enable
	input wire logic [1:0] sys_src, // Source option
	input wire logic slow_osc_soft_stop_allow, // Stop option
	input wire logic slow_osc_clk, // Raw slow clock
	input wire logic stop_release, // STOP release pulse
	input wire logic cpu_clk_en, // CPU enable
	input wire logic per_clk_en, // Peripheral enable
	input wire logic slow_osc_run, // Slow osc enable
	input wire logic wdt_stopped, // Watchdog stopped
	input wire logic tmh_clk, // Timer clock
	input wire logic stab_busy, // Wait under way
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready // Write response ready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_run_hold; $past(ce) && !$past(slow_osc_soft_stop_allow) |-> slow_osc_run; endproperty
	a_run_hold: assert property (p_run_hold) else $error("slow osc stopped");
	property p_run_low; !slow_osc_run |-> $past(slow_osc_soft_stop_allow); endproperty
	a_run_low: assert property (p_run_low) else $error("slow osc low without option");
	property p_tmh;
		$past(ce) |-> tmh_clk == ($past(slow_osc_clk) && $past(slow_osc_run));
	endproperty
	a_tmh: assert property (p_tmh) else $error("timer clock without slow osc");
	property p_wdt; wdt_stopped |-> $past(slow_osc_soft_stop_allow); endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog stopped without option");
	property p_ratio; cpu_clk_en |-> per_clk_en; endproperty
	a_ratio: assert property (p_ratio) else $error("cpu pulse off peripheral grid");
	property p_src; stab_busy |-> sys_src == CKDOC_SRC_RESONATOR; endproperty
	a_src: assert property (p_src) else $error("wait without resonator");
	property p_quiet; stab_busy |-> !cpu_clk_en && !per_clk_en; endproperty
	a_quiet: assert property (p_quiet) else $error("enables during wait");
	property p_start; $rose(stab_busy) |-> $past(stop_release); endproperty
	a_start: assert property (p_start) else $error("wait without release");
	property p_hold; $rose(stab_busy) |=> stab_busy [*8]; endproperty
	a_hold: assert property (p_hold) else $error("wait too short");
	c_busy: cover property ($rose(stab_busy));
	c_osc: cover property ($fell(slow_osc_run));
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // ckdoc_checker

bind ckdoc_top ckdoc_checker u_chk (.clk_sys, .reset, .ce, .sys_src, .slow_osc_soft_stop_allow,
	.slow_osc_clk, .stop_release, .cpu_clk_en, .per_clk_en, .slow_osc_run, .wdt_stopped,
	.tmh_clk, .stab_busy, .s_axi_bvalid, .s_axi_bready);

// ==== verif/ckdoc_tb.sv ====
// Self-checking bench for the clock control block.
// Assumes the register slave answers well within the cycle ceiling.
`timescale 1ns/10ps
module testbench;
	import ckdoc_pkg::*;
	logic clk_sys = 1'b0, reset = 1'b1, ce = 1'b1, slow_osc_soft_stop_allow = 1'b0;
	logic slow_osc_clk = 1'b0, wdt_stop_req = 1'b0, wdt_sysclk_req = 1'b0;
	logic stop_mode = 1'b0, stop_release = 1'b0;
	logic [1:0] sys_src = 2'h1;
	logic cpu_clk_en, per_clk_en, slow_osc_run, wdt_clk, wdt_stopped, tmh_clk, stab_busy;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] code;
	int n_fail = 0, compares = 0, cycles = 0, busy_n = 0, nc, np, j;
	int cpu_d[6] = '{1, 4, 2, 8, 4, 16};
	int per_d[6] = '{1, 1, 2, 2, 4, 4};

	ckdoc_top uut (.clk_sys, .reset, .ce, .sys_src, .slow_osc_soft_stop_allow, .slow_osc_clk,
		.wdt_stop_req, .wdt_sysclk_req, .stop_mode, .stop_release, .cpu_clk_en, .per_clk_en,
		.slow_osc_run, .wdt_clk, .wdt_stopped, .tmh_clk, .stab_busy, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	always #4 clk_sys = ~clk_sys;

	// Slow clock and wait length are tracked here; a hang ends in the report
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		slow_osc_clk <= cycles[3];
		if (stop_release) busy_n <= 0;
		else if (stab_busy === 1'b1) busy_n <= busy_n + 1;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check(s_axi_rresp, er);
		check(s_axi_rdata, exp);
	endtask

	task automatic count_en(input int n);
		nc = 0;
		np = 0;
		repeat (n) begin
			@(posedge clk_sys);
			if (cpu_clk_en === 1'b1) nc++;
			if (per_clk_en === 1'b1) np++;
		end
	endtask

	task automatic stop_cycle();
		@(posedge clk_sys);
		stop_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		stop_mode <= 1'b0;
		stop_release <= 1'b1;
		@(posedge clk_sys);
		stop_release <= 1'b0;
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rdc(CKDOC_OFS_PRESCALE, 32'h4, CKDOC_RESP_OKAY);
		rdc(CKDOC_OFS_CPUCTL, 32'h0, CKDOC_RESP_OKAY);
		rdc(CKDOC_OFS_SLOWOSC, 32'h2, CKDOC_RESP_OKAY);
		rdc(CKDOC_OFS_STAB, 32'h0, CKDOC_RESP_OKAY);
		rdc(32'h10, 32'h0, CKDOC_RESP_SLVERR);
		wr(CKDOC_OFS_CPUCTL, 32'h2, 4'h0, CKDOC_RESP_OKAY);
		rdc(CKDOC_OFS_CPUCTL, 32'h0, CKDOC_RESP_OKAY);
		wr(CKDOC_OFS_STAB, 32'hFF, 4'hF, CKDOC_RESP_OKAY);
		rdc(CKDOC_OFS_STAB, 32'h3, CKDOC_RESP_OKAY);
		// every legal code, then a prohibited one that must keep the old ratio
		for (int k = 0; k < 7; k++) begin
			code = (k < 6) ? 3'(k) : 3'h7;
			j = (k < 6) ? k : 5;
			wr(CKDOC_OFS_PRESCALE, {30'h0, code[2:1]}, 4'hF, CKDOC_RESP_OKAY);
			wr(CKDOC_OFS_CPUCTL, {30'h0, code[0], 1'b0}, 4'hF, CKDOC_RESP_OKAY);
			repeat (40) @(posedge clk_sys);
			rdc(CKDOC_OFS_PRESCALE, {29'h0, k < 6, code[2:1]}, CKDOC_RESP_OKAY);
			count_en(96);
			check(nc, 96 / cpu_d[j]);
			check(np, 96 / per_d[j]);
		end
		wr(CKDOC_OFS_PRESCALE, 32'h0, 4'hF, CKDOC_RESP_OKAY);
		wr(CKDOC_OFS_CPUCTL, 32'h0, 4'hF, CKDOC_RESP_OKAY);
		// stop request ignored until the option allows it
		wr(CKDOC_OFS_SLOWOSC, 32'h1, 4'hF, CKDOC_RESP_OKAY);
		@(posedge clk_sys);
		wdt_stop_req <= 1'b1;
		rdc(CKDOC_OFS_SLOWOSC, 32'h3, CKDOC_RESP_OKAY);
		check(wdt_stopped, 1'b0);
		@(posedge clk_sys);
		slow_osc_soft_stop_allow <= 1'b1;
		rdc(CKDOC_OFS_SLOWOSC, 32'h1, CKDOC_RESP_OKAY);
		check(slow_osc_run, 1'b0);
		check(wdt_stopped, 1'b1);
		check(wdt_clk, 1'b0);
		check(tmh_clk, 1'b0);
		wr(CKDOC_OFS_SLOWOSC, 32'h0, 4'hF, CKDOC_RESP_OKAY);
		wdt_stop_req <= 1'b0;
		rdc(CKDOC_OFS_SLOWOSC, 32'h2, CKDOC_RESP_OKAY);
		// Watchdog on the system clock follows the undivided cpu enable
		wdt_sysclk_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check(wdt_clk, 1'b1);
		wdt_sysclk_req <= 1'b0;
		// shortest wait with a resonator, then none for the internal source
		wr(CKDOC_OFS_STAB, 32'h0, 4'hF, CKDOC_RESP_OKAY);
		stop_cycle();
		rdc(CKDOC_OFS_STAB, 32'h4, CKDOC_RESP_OKAY);
		repeat (1100) @(posedge clk_sys);
		check(busy_n, 1 << CKDOC_STAB_EXP0);
		count_en(16);
		check(nc, 16);
		sys_src <= 2'h0;
		stop_cycle();
		repeat (20) @(posedge clk_sys);
		check(busy_n, 0);
		count_en(16);
		check(nc, 16);
		// Frozen by ce, a STOP entry and release with a resonator must leave no wait behind
		sys_src <= 2'h1;
		ce <= 1'b0;
		stop_cycle();
		ce <= 1'b1;
		count_en(16);
		check(nc, 16);
		check(busy_n, 0);
		report_and_stop();
	end
endmodule // testbench
